// ### bench/drive_operating_mode_selector_tb.sv
// self-checking bench for the operating mode selector
`timescale 1ns/1ps
`default_nettype none
`include "mode_sel_defs.svh"
module drive_operating_mode_selector_tb;
   logic        sys_clk_in = 0, rst_in = 1, drive_ready_in = 1;
   logic        standstill_in = 0, error_cancel_in = 0, error_active_in = 0;
   logic        target_reached_in = 0;
   logic        param_wr_in, param_rd_in, param_ack_out, param_err_out;
   logic        mode_active_out, mode_go_out, halt_out, op_enable_out;
   logic [15:0] param_addr_in, param_wdata_in, param_rdata_out, mode_out;
   logic [2:0]  mode_bits_out, jog_bits_out;
   logic [15:0] codes [4] = '{`MODE_PROFILE_POS, `MODE_PROFILE_VEL,
                              `MODE_HOMING, `MODE_JOG};
   int          miscompares = 0, checks = 0;
   drive_operating_mode_selector i_drive_operating_mode_selector (
      .sys_clk_in, .rst_in, .param_wr_in, .param_rd_in, .param_addr_in,
      .param_wdata_in, .drive_ready_in, .standstill_in,
      .target_reached_in, .error_cancel_in, .error_active_in,
      .param_rdata_out, .param_ack_out, .param_err_out, .mode_out,
      .mode_active_out, .mode_go_out, .mode_bits_out, .halt_out,
      .op_enable_out, .jog_bits_out);
   fieldbus_master_model i_fieldbus_master_model (
      .sys_clk_in, .ack_in (param_ack_out), .err_in (param_err_out),
      .rdata_in (param_rdata_out), .wr_out (param_wr_in),
      .rd_out (param_rd_in), .addr_out (param_addr_in),
      .wdata_out (param_wdata_in));
   initial forever #20 sys_clk_in = ~sys_clk_in;
   task automatic chk(input logic [15:0] got, exp);
      checks++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         miscompares++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, d, input logic ee);
      logic [15:0] q;
      logic        e;
      i_fieldbus_master_model.access(1'b1, a, d, q, e);
      chk({15'h0000, e}, {15'h0000, ee});
   endtask
   task automatic rd(input logic [15:0] a, x, input logic ee);
      logic [15:0] q;
      logic        e;
      i_fieldbus_master_model.access(1'b0, a, 16'h0000, q, e);
      chk({15'h0000, e}, {15'h0000, ee});
      if (!ee) chk(q, x);
   endtask
   // halt, then standstill ends the mode; halt cleared after
   task automatic stop_mode;
      wr(`ADDR_CONTROL_WORD, 16'h010f, 1'b0);
      chk({15'h0000, halt_out}, 16'h0001);
      standstill_in = 1;
      tick(4);
      chk({15'h0000, mode_active_out}, 16'h0000);
      standstill_in = 0;
      wr(`ADDR_CONTROL_WORD, 16'h000f, 1'b0);
   endtask
   task automatic t_reset;
      rd(`ADDR_MODE_RUNNING, `MODE_NONE, 1'b0);
      rd(`ADDR_MANUAL_MOVE, `MM_RESET, 1'b0);
      rd(16'h1b00, 16'h0000, 1'b1);
   endtask
   task automatic t_enable;
      wr(`ADDR_MODE_REQUEST, `MODE_PROFILE_POS, 1'b1);
      chk(mode_out, `MODE_NONE);
      wr(`ADDR_CONTROL_WORD, 16'h020f, 1'b0);
      rd(`ADDR_CONTROL_WORD, 16'h0000, 1'b0);
      wr(`ADDR_CONTROL_WORD, 16'h000f, 1'b0);
      tick(1);
      chk({15'h0000, op_enable_out}, 16'h0001);
   endtask
   task automatic t_modes;
      foreach (codes[i]) begin
         if (codes[i] === `MODE_JOG)
            wr(`ADDR_MANUAL_MOVE, 16'h0005, 1'b0);
         wr(`ADDR_MODE_REQUEST, codes[i], 1'b0);
         chk(mode_out, codes[i]);
         rd(`ADDR_MODE_RUNNING, codes[i], 1'b0);
         wr(`ADDR_MODE_REQUEST, codes[(i + 1) % 4], 1'b1);
         chk(mode_out, codes[i]);
         rd(`ADDR_MODE_REQUEST, codes[i], 1'b0);
         stop_mode();
      end
      wr(`ADDR_MODE_REQUEST, 16'h0002, 1'b1);
      wr(`ADDR_MODE_REQUEST, 16'h0007, 1'b1);
      chk({13'h0000, jog_bits_out}, 16'h0005);
      wr(`ADDR_MANUAL_MOVE, 16'h0008, 1'b0);
      chk({13'h0000, jog_bits_out}, 16'h0005);
   endtask
   // target reached, then standstill ends the mode; code is kept
   task automatic t_target;
      wr(`ADDR_MODE_REQUEST, `MODE_PROFILE_VEL, 1'b0);
      target_reached_in = 1;
      tick(1);
      target_reached_in = 0;
      chk({15'h0000, mode_active_out}, 16'h0001);
      standstill_in = 1;
      tick(2);
      standstill_in = 0;
      chk({15'h0000, mode_active_out}, 16'h0000);
      rd(`ADDR_MODE_RUNNING, `MODE_PROFILE_VEL, 1'b0);
   endtask
   task automatic t_start;
      wr(`ADDR_MODE_REQUEST, `MODE_PROFILE_POS, 1'b0);
      chk({15'h0000, mode_go_out}, 16'h0000);
      wr(`ADDR_CONTROL_WORD, 16'h001f, 1'b0);
      tick(1);
      chk({15'h0000, mode_go_out}, 16'h0001);
      chk({13'h0000, mode_bits_out}, 16'h0001);
   endtask
   task automatic t_error;
      error_cancel_in = 1;
      error_active_in = 1;
      tick(2);
      error_cancel_in = 0;
      chk({15'h0000, mode_active_out}, 16'h0000);
      wr(`ADDR_MODE_REQUEST, `MODE_PROFILE_VEL, 1'b1);
      error_active_in = 0;
      wr(`ADDR_MODE_REQUEST, `MODE_PROFILE_VEL, 1'b0);
      chk(mode_out, `MODE_PROFILE_VEL);
      stop_mode();
   endtask
   task automatic t_ready;
      drive_ready_in = 0;
      wr(`ADDR_MODE_REQUEST, `MODE_HOMING, 1'b1);
      chk({15'h0000, mode_active_out}, 16'h0000);
      drive_ready_in = 1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      tick(20);
      rst_in = 0;
      t_reset();
      t_enable();
      t_modes();
      t_start();
      t_error();
      t_ready();
      t_target();
      tally_and_finish();
   end
   // watchdog well beyond the roughly 140 cycles the run needs
   initial begin
      #100000;
      miscompares++;
      tally_and_finish();
   end
endmodule
bind drive_operating_mode_selector mode_sel_checker i_mode_sel_checker (
   .sys_clk_in, .rst_in, .param_wr_in, .param_rd_in, .param_addr_in,
   .param_wdata_in, .standstill_in, .param_rdata_out, .param_ack_out,
   .mode_out, .mode_active_out, .halt_out, .op_enable_out, .jog_bits_out);
`default_nettype wire

// ### bench/fieldbus_master_model.sv
// fieldbus master issuing single word parameter accesses
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
   input  wire logic        sys_clk_in,
   input  wire logic        ack_in,
   input  wire logic        err_in,
   input  wire logic [15:0] rdata_in,
   output var  logic        wr_out,
   output var  logic        rd_out,
   output var  logic [15:0] addr_out,
   output var  logic [15:0] wdata_out
);
   initial {wr_out, rd_out, addr_out, wdata_out} = 34'h0_0000_0000;
   task automatic access(input logic w, input logic [15:0] a, d,
                         output logic [15:0] q, output logic e);
      int n;
      @(posedge sys_clk_in);
      #1;
      {wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, d};
      @(posedge sys_clk_in);
      #1;
      // released lines show inverted values, never stale ones
      {wr_out, rd_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
      for (n = 0; n < 4 && ack_in !== 1'b1; n++) begin
         @(posedge sys_clk_in);
         #1;
      end
      q = rdata_in;
      e = (ack_in === 1'b1) ? err_in : 1'bx;
   endtask
endmodule
`default_nettype wire

// ### bench/mode_sel_checker.sv
// port assertions for the operating mode selector
`timescale 1ns/1ps
`default_nettype none
`include "mode_sel_defs.svh"
module mode_sel_checker (
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   input wire logic        param_wr_in,
   input wire logic        param_rd_in,
   input wire logic [15:0] param_addr_in,
   input wire logic [15:0] param_wdata_in,
   input wire logic        standstill_in,
   input wire logic [15:0] param_rdata_out,
   input wire logic        param_ack_out,
   input wire logic [15:0] mode_out,
   input wire logic        mode_active_out,
   input wire logic        halt_out,
   input wire logic        op_enable_out,
   input wire logic [2:0]  jog_bits_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // write strobes decoded for control word and manual move
   wire w_ctl = param_wr_in && param_addr_in == `ADDR_CONTROL_WORD;
   wire w_jog = param_wr_in && param_addr_in == `ADDR_MANUAL_MOVE;
   property p_ack; param_wr_in || param_rd_in |=> param_ack_out; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_code; mode_active_out |-> mode_out inside {`MODE_PROFILE_POS,
      `MODE_PROFILE_VEL, `MODE_HOMING, `MODE_JOG}; endproperty
   a_code: assert property (p_code) else $error("bad code");
   property p_hold;
      mode_active_out && $past(mode_active_out) |-> $stable(mode_out);
   endproperty
   a_hold: assert property (p_hold) else $error("mode switched");
   property p_enable;
      $rose(mode_active_out) |-> $past(op_enable_out); endproperty
   a_enable: assert property (p_enable) else $error("not enabled");
   property p_halt; w_ctl && param_wdata_in[15:9] == 7'h00
      |=> halt_out == $past(param_wdata_in[8]); endproperty
   a_halt: assert property (p_halt) else $error("halt bit");
   property p_jog; w_jog && param_wdata_in <= 16'h0007
      |=> jog_bits_out == $past(param_wdata_in[2:0]); endproperty
   a_jog: assert property (p_jog) else $error("jog bits");
   property p_stop; mode_active_out && halt_out && standstill_in
      |-> ##[1:3] !mode_active_out; endproperty
   a_stop: assert property (p_stop) else $error("no stop");
   property p_rd; param_rd_in && param_addr_in == `ADDR_MODE_RUNNING
      |=> param_rdata_out == $past(mode_out); endproperty
   a_rd: assert property (p_rd) else $error("running read");
   c_start: cover property ($rose(mode_active_out));
   c_stop: cover property ($fell(mode_active_out));
   c_halt: cover property (w_ctl ##1 halt_out);
endmodule
`default_nettype wire

// ### design/drive_operating_mode_selector.sv
// operating mode selection and activation for a motor drive
`timescale 1ns/1ps
`default_nettype none
`include "mode_sel_defs.svh"

// Contract
// - at most one operating mode active; never two at once.
// - switching modes only after current mode terminated or cancelled.
// - mode terminates when the drive reaches standstill.
// - after error cancel, resume or reselect only once error cleared.
// - mode activation accepted only in operation-enable state.
// - no mode starts unless drive ready and initialised.
// - mode started by writing signed 16-bit mode select parameter.
// - manual move request bits: positive, negative, fast; range 0..7.
// - codes: position 1, velocity 3, homing 6, jog -1; range -6..6.
// - position and homing start only on control word bit 4.
// - other modes use control bits 4..6 as mode specific.
// - read-only active mode indication, same coding as select.
// - control word 16-bit; bits 0-3,7 state; bits 9-15 zero.
// - control bit 8 requests halt, ending mode at standstill.
// - operation enable entered with control bits 0..3 all set.
module drive_operating_mode_selector (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic        param_wr_in,
   input  wire logic        param_rd_in,
   input  wire logic [15:0] param_addr_in,
   input  wire logic [15:0] param_wdata_in,
   input  wire logic        drive_ready_in,
   input  wire logic        standstill_in,
   input  wire logic        target_reached_in,
   input  wire logic        error_cancel_in,
   input  wire logic        error_active_in,
   output logic [15:0]      param_rdata_out,
   output logic             param_ack_out,
   output logic             param_err_out,
   output logic [15:0]      mode_out,
   output logic             mode_active_out,
   output logic             mode_go_out,
   output logic [2:0]       mode_bits_out,
   output logic             halt_out,
   output logic             op_enable_out,
   output logic [2:0]       jog_bits_out
);
   import mode_sel_pkg::*;

   logic [15:0] request_q;
   logic [15:0] running_q;
   logic [15:0] control_q;
   logic [15:0] control_prev_q;
   logic [2:0]  jog_q;
   logic        op_enable_q;
   logic        started_q;
   mode_state_t state_q;
   logic        supported;
   logic        needs_start;
   logic        wr_mode;
   logic        wr_ctrl;
   logic        wr_jog;
   logic        in_range;
   logic        mode_ok;
   logic        halt_req;

   // code check kept apart so the supported set lives in one place
   mode_code_check i_mode_code_check (
      .code_in         (param_wdata_in),
      .supported_out   (supported),
      .needs_start_out (needs_start)
   );

   // write decode
   assign wr_mode = param_wr_in && (param_addr_in == `ADDR_MODE_REQUEST);
   assign wr_ctrl = param_wr_in && (param_addr_in == `ADDR_CONTROL_WORD);
   assign wr_jog  = param_wr_in && (param_addr_in == `ADDR_MANUAL_MOVE);
   assign in_range = ($signed(param_wdata_in) >= $signed(`MODE_MIN)) &&
                     ($signed(param_wdata_in) <= $signed(`MODE_MAX));
   // halt is a level; the mode stays stopping until standstill
   assign halt_req = control_q[`CW_HALT_BIT];

   // mode write accepted only when no mode runs
   // error must be cleared first
   // a cancelled mode is resumed by writing the same code again
   assign mode_ok = (state_q == ST_IDLE || state_q == ST_CANCELLED) &&
                    op_enable_q && drive_ready_in && !error_active_in &&
                    supported && in_range;

   // control word store; reserved bits must be zero
   // a word with reserved bits set is dropped whole, not masked
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         control_q      <= `CW_RESET;
         control_prev_q <= `CW_RESET;
      end else begin
         control_prev_q <= control_q;
         if (wr_ctrl && (param_wdata_in & `CW_RESERVED_MASK) == 16'h0000) begin
            control_q <= param_wdata_in;
         end
      end
   end

   // operation enable tracks control bits 0..3
   // one cycle late: a mode write on the very next cycle is refused
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         op_enable_q <= 1'b0;
      end else begin
         op_enable_q <= ((control_q & `CW_ENABLE_MASK) == `CW_ENABLE_MASK)
                        && drive_ready_in;
      end
   end

   // manual move request, three bits
   // values above the range are dropped whole
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         jog_q <= 3'h0;
      end else if (wr_jog &&
                   (param_wdata_in & ~`MM_VALID_MASK) == 16'h0000) begin
         jog_q <= param_wdata_in[2:0];
      end
   end

   // refused writes leave running mode alone
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         request_q <= `MODE_NONE;
      end else if (wr_mode && mode_ok) begin
         request_q <= param_wdata_in;
      end
   end

   // single mode state machine
   // cancelling wins over halt so an error never looks like a stop
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_q   <= ST_IDLE;
         running_q <= `MODE_NONE;
      end else begin
         unique case (state_q)
            ST_IDLE, ST_CANCELLED: begin
               if (wr_mode && mode_ok) begin
                  state_q   <= ST_RUNNING;
                  running_q <= param_wdata_in;
               end
            end
            ST_RUNNING: begin
               if (error_cancel_in || !op_enable_q) begin
                  state_q <= ST_CANCELLED;
               end else if (halt_req || target_reached_in) begin
                  state_q <= ST_STOPPING;
               end
            end
            ST_STOPPING: begin
               if (error_cancel_in) begin
                  state_q <= ST_CANCELLED;
               end else if (standstill_in) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // position and homing wait for rising bit 4
   // edge, not level: a bit left high must not start the next mode
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         started_q <= 1'b0;
      end else if (state_q != ST_RUNNING) begin
         started_q <= 1'b0;
      end else if (control_q[`CW_START_BIT] &&
                   !control_prev_q[`CW_START_BIT]) begin
         started_q <= 1'b1;
      end
   end

   // outputs to the motion core
   // mode_out keeps the last code after termination for diagnosis
   assign mode_out        = running_q;
   assign mode_active_out = (state_q == ST_RUNNING) ||
                            (state_q == ST_STOPPING);
   assign mode_go_out     = (state_q == ST_RUNNING) &&
      ((running_q == `MODE_PROFILE_POS || running_q == `MODE_HOMING) ?
       started_q : 1'b1);
   // bits 4..6 passed through with mode specific meaning
   assign mode_bits_out = control_q[6:4];
   assign halt_out      = halt_req;
   assign op_enable_out = op_enable_q;
   assign jog_bits_out  = jog_q;

   // read back, indication is read only
   // of writes, a refused mode write or one to another address raises err; bad control or jog
   // words are dropped quietly and must be read back to be seen
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         param_rdata_out <= 16'h0000;
         param_ack_out   <= 1'b0;
         param_err_out   <= 1'b0;
      end else begin
         param_ack_out <= param_rd_in || param_wr_in;
         param_err_out <= 1'b0;
         param_rdata_out <= 16'h0000;
         if (param_rd_in) begin
            unique case (param_addr_in)
               `ADDR_CONTROL_WORD: param_rdata_out <= control_q;
               `ADDR_MODE_REQUEST: param_rdata_out <= request_q;
               `ADDR_MODE_RUNNING: param_rdata_out <= running_q;
               `ADDR_MANUAL_MOVE:  param_rdata_out <= {13'h0000, jog_q};
               default:            param_err_out   <= 1'b1;
            endcase
         end else if (param_wr_in) begin
            param_err_out <= !(wr_ctrl || wr_jog || (wr_mode && mode_ok));
         end
      end
   end
endmodule
`default_nettype wire

// ### design/mode_code_check.sv
// checks a requested mode code against the supported set
`timescale 1ns/1ps
`default_nettype none
`include "mode_sel_defs.svh"

module mode_code_check (
   input  wire logic [15:0] code_in,
   output logic             supported_out,
   output logic             needs_start_out
);
   // only documented modes are accepted; others in range are refused
   always_comb begin
      supported_out = (code_in == `MODE_PROFILE_POS) ||
                      (code_in == `MODE_PROFILE_VEL) ||
                      (code_in == `MODE_HOMING) ||
                      (code_in == `MODE_JOG);
      needs_start_out = (code_in == `MODE_PROFILE_POS) ||
                        (code_in == `MODE_HOMING);
   end
endmodule
`default_nettype wire

// ### design/mode_sel_defs.svh
// constants for the drive operating mode selector
`ifndef MODE_SEL_DEFS_SVH
`define MODE_SEL_DEFS_SVH

// parameter addresses (fieldbus word addresses)
`define ADDR_CONTROL_WORD   16'h1b02
`define ADDR_MODE_REQUEST   16'h1b06
`define ADDR_MODE_RUNNING   16'h1b08
`define ADDR_MANUAL_MOVE    16'h1b12

// mode codes
`define MODE_NONE           16'h0000
`define MODE_PROFILE_POS    16'h0001
`define MODE_PROFILE_VEL    16'h0003
`define MODE_HOMING         16'h0006
`define MODE_JOG            16'hffff
`define MODE_MIN            16'hfffa
`define MODE_MAX            16'h0006

// control word fields
`define CW_ENABLE_MASK      16'h000f
`define CW_START_BIT        4
`define CW_FAULT_RESET_BIT  7
`define CW_HALT_BIT         8
`define CW_RESERVED_MASK    16'hfe00

// manual move request fields; manual move and control word reset values
`define MM_VALID_MASK       16'h0007
`define MM_RESET            16'h0000
`define CW_RESET            16'h0000

`endif

// ### design/mode_sel_pkg.sv
// types for the drive operating mode selector
package mode_sel_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUNNING,
      ST_STOPPING,
      ST_CANCELLED
   } mode_state_t;
endpackage
